// file: core/adc_out_defines.svh
// register offsets, field positions, reset values and link constants
`ifndef ADC_OUT_DEFINES_SVH
`define ADC_OUT_DEFINES_SVH

`define WORD_BITS 5'h10
`define ADDR_DONE_BITS 5'h08
`define RW_BIT 15
`define ADDR_MSB 14
`define ADDR_LSB 8

`define ADDR_SOFT_RESET 7'h00
`define ADDR_OUTPUT_MODE 7'h02
`define ADDR_PATTERN_HIGH 7'h03
`define ADDR_PATTERN_LOW 7'h04
`define SOFT_RESET_BIT 7

`define MODE_RESET 8'h00
`define PATTERN_HIGH_RESET 8'h00
`define PATTERN_LOW_RESET 8'h00

`define CURRENT_MSB 7
`define CURRENT_LSB 5
`define TERMINATION_BIT 4
`define OUTPUT_DISABLE_BIT 3
`define FORMAT_MSB 2
`define FORMAT_LSB 0
`define PATTERN_ENABLE_BIT 7
`define PATTERN_UPPER_MSB 5
`define PATTERN_LOWER_MSB 7
`define PATTERN_LOWER_LSB 2
`define PATTERN_EXTRA_MSB 1

`define CURRENT_4P0 6'h28
`define CURRENT_4P5 6'h2D
`define CURRENT_3P0 6'h1E
`define CURRENT_2P5 6'h19
`define CURRENT_2P1 6'h15
`define CURRENT_DEFAULT 6'h23

`endif

// file: core/adc_out_pkg.sv
// types shared by the output mode register bank
package adc_out_pkg;
    typedef enum logic [2:0] {
        cur_default = 3'h0,
        cur_4p0 = 3'h1,
        cur_4p5 = 3'h2,
        cur_unused = 3'h3,
        cur_3p0 = 3'h4,
        cur_2p5 = 3'h5,
        cur_2p1 = 3'h6,
        cur_spare = 3'h7
    } current_code_t;

    typedef enum logic [2:0] {
        fmt_2l_16 = 3'h0,
        fmt_2l_14 = 3'h1,
        fmt_2l_12 = 3'h2,
        fmt_unused_a = 3'h3,
        fmt_unused_b = 3'h4,
        fmt_1l_14 = 3'h5,
        fmt_1l_12 = 3'h6,
        fmt_1l_16 = 3'h7
    } format_code_t;
endpackage

// file: core/spi_word_if.sv
// carrier between the serial word receiver and the register bank
`timescale 1ns/1ps
interface spi_word_if;
    logic addr_valid;
    logic wr_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport rx
    (
        output addr_valid,
        output wr_stb,
        output addr,
        output wdata,
        input rdata
    );

    modport regs
    (
        input addr_valid,
        input wr_stb,
        input addr,
        input wdata,
        output rdata
    );
endinterface

// file: core/spi_word_rx.sv
// serial word receiver: samples the serial pins, decodes 16-bit words
`timescale 1ns/1ps
`include "adc_out_defines.svh"
module spi_word_rx
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // register side
    spi_word_if.rx bus
);
    // ==========================================
    // pin synchronisers
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sck_prev;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // idle levels: deselected, link clock low
            sync1 <= 3'h4;
            sync2 <= 3'h4;
            sck_prev <= 1'b0;
        end
        else
        begin
            sync1 <= {cs_n, sck, sdi};
            sync2 <= sync1;
            sck_prev <= sync2[1];
        end
    end

    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    assign cs_act = !sync2[2];
    assign sck_rise = cs_act && sync2[1] && !sck_prev;
    assign sck_fall = cs_act && !sync2[1] && sck_prev;

    // ==========================================
    // word shifter and read-back
    logic [4:0] cnt;
    logic [15:0] shreg;
    logic [7:0] rd_shift;
    logic sdo_low;
    logic rd_cmd;
    logic addr_valid;
    logic wr_stb;
    logic [4:0] next_cnt;
    logic [15:0] next_shreg;
    logic [7:0] next_rd_shift;
    logic next_sdo_low;
    logic next_rd_cmd;
    logic next_addr_valid;
    logic next_wr_stb;

    always_comb
    begin
        next_cnt = cnt;
        next_shreg = shreg;
        next_rd_shift = rd_shift;
        next_sdo_low = sdo_low;
        next_rd_cmd = rd_cmd;
        next_addr_valid = 1'b0;
        next_wr_stb = 1'b0;
        if (!cs_act)
        begin
            next_cnt = 5'h00;
            next_sdo_low = 1'b0;
            next_rd_cmd = 1'b0;
        end
        else if (sck_rise && cnt != `WORD_BITS)
        begin
            // edges past the sixteenth are ignored
            next_cnt = cnt + 5'h01;
            next_shreg = {shreg[14:0], sync2[0]};
            next_addr_valid = (next_cnt == `ADDR_DONE_BITS);
            next_wr_stb = (next_cnt == `WORD_BITS) && !shreg[`RW_BIT - 1];
        end
        else if (sck_fall && rd_cmd && cnt >= `ADDR_DONE_BITS && cnt != `WORD_BITS)
        begin
            next_sdo_low = !rd_shift[7];
            next_rd_shift = {rd_shift[6:0], 1'b0};
        end
        if (addr_valid)
        begin
            // direction bit sits at bit 7 only while the count is eight
            next_rd_cmd = shreg[`RW_BIT - 8];
            next_rd_shift = bus.rdata;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= 5'h00;
            shreg <= 16'h0000;
            rd_shift <= 8'h00;
            sdo_low <= 1'b0;
            rd_cmd <= 1'b0;
            addr_valid <= 1'b0;
            wr_stb <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            shreg <= next_shreg;
            rd_shift <= next_rd_shift;
            sdo_low <= next_sdo_low;
            rd_cmd <= next_rd_cmd;
            addr_valid <= next_addr_valid;
            wr_stb <= next_wr_stb;
        end
    end

    // address sits in the low seven bits after eight edges
    assign bus.addr = addr_valid ? shreg[6:0] : shreg[`ADDR_MSB:`ADDR_LSB];
    assign bus.wdata = shreg[7:0];
    assign bus.addr_valid = addr_valid;
    assign bus.wr_stb = wr_stb;
    // open drain: only ever pulls low
    assign sdo_out = 1'b0;
    assign sdo_oe = sdo_low;
endmodule

// file: core/adc_out_regs.sv
// output mode and test pattern register bank with serial access
`timescale 1ns/1ps
`include "adc_out_defines.svh"
module adc_out_regs
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // serial configuration pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // conversion data in
    input wire logic [11:0] conv_a,
    input wire logic [11:0] conv_b,
    // data toward the serializer
    output logic [11:0] out_a,
    output logic [11:0] out_b,
    output logic [1:0] out_extra,
    output logic outputs_enabled,
    output logic pattern_active,
    // driver and format controls
    output logic [5:0] driver_current_tenth_ma,
    output logic termination_enable,
    output logic two_lanes,
    output logic [4:0] serial_bits,
    output logic format_valid
);
    spi_word_if bus();

    spi_word_rx u_rx
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .cs_n(cs_n),
        .sck(sck),
        .sdi(sdi),
        .sdo_out(sdo_out),
        .sdo_oe(sdo_oe),
        .bus(bus)
    );

    // ==========================================
    // registers
    logic [7:0] output_mode_control;
    logic [7:0] test_pattern_high;
    logic [7:0] test_pattern_low;
    logic [7:0] next_output_mode_control;
    logic [7:0] next_test_pattern_high;
    logic [7:0] next_test_pattern_low;

    always_comb
    begin
        next_output_mode_control = output_mode_control;
        next_test_pattern_high = test_pattern_high;
        next_test_pattern_low = test_pattern_low;
        if (bus.wr_stb)
        begin
            case (bus.addr)
                `ADDR_SOFT_RESET:
                begin
                    if (bus.wdata[`SOFT_RESET_BIT])
                    begin
                        next_output_mode_control = `MODE_RESET;
                        next_test_pattern_high = `PATTERN_HIGH_RESET;
                        next_test_pattern_low = `PATTERN_LOW_RESET;
                    end
                end
                `ADDR_OUTPUT_MODE: next_output_mode_control = bus.wdata;
                `ADDR_PATTERN_HIGH: next_test_pattern_high = bus.wdata;
                `ADDR_PATTERN_LOW: next_test_pattern_low = bus.wdata;
                default: next_output_mode_control = output_mode_control;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            output_mode_control <= `MODE_RESET;
            test_pattern_high <= `PATTERN_HIGH_RESET;
            test_pattern_low <= `PATTERN_LOW_RESET;
        end
        else
        begin
            output_mode_control <= next_output_mode_control;
            test_pattern_high <= next_test_pattern_high;
            test_pattern_low <= next_test_pattern_low;
        end
    end

    // read-back; reset register and unmapped addresses read zero
    always_comb
    begin
        case (bus.addr)
            `ADDR_OUTPUT_MODE: bus.rdata = output_mode_control;
            `ADDR_PATTERN_HIGH: bus.rdata = test_pattern_high;
            `ADDR_PATTERN_LOW: bus.rdata = test_pattern_low;
            default: bus.rdata = 8'h00;
        endcase
    end

    // ==========================================
    // field decode
    adc_out_pkg::current_code_t cur_code;
    adc_out_pkg::format_code_t fmt_code;
    assign cur_code = adc_out_pkg::current_code_t'(
        output_mode_control[`CURRENT_MSB:`CURRENT_LSB]);
    assign fmt_code = adc_out_pkg::format_code_t'(
        output_mode_control[`FORMAT_MSB:`FORMAT_LSB]);

    logic [5:0] next_current;
    logic next_two_lanes;
    logic [4:0] next_bits;
    logic next_fmt_valid;
    logic [11:0] pattern;

    always_comb
    begin
        case (cur_code)
            adc_out_pkg::cur_4p0: next_current = `CURRENT_4P0;
            adc_out_pkg::cur_4p5: next_current = `CURRENT_4P5;
            adc_out_pkg::cur_3p0: next_current = `CURRENT_3P0;
            adc_out_pkg::cur_2p5: next_current = `CURRENT_2P5;
            adc_out_pkg::cur_2p1: next_current = `CURRENT_2P1;
            default: next_current = `CURRENT_DEFAULT;
        endcase
    end

    always_comb
    begin
        next_fmt_valid = 1'b1;
        case (fmt_code)
            adc_out_pkg::fmt_2l_16: {next_two_lanes, next_bits} = {1'b1, 5'h10};
            adc_out_pkg::fmt_2l_14: {next_two_lanes, next_bits} = {1'b1, 5'h0E};
            adc_out_pkg::fmt_2l_12: {next_two_lanes, next_bits} = {1'b1, 5'h0C};
            adc_out_pkg::fmt_1l_14: {next_two_lanes, next_bits} = {1'b0, 5'h0E};
            adc_out_pkg::fmt_1l_12: {next_two_lanes, next_bits} = {1'b0, 5'h0C};
            adc_out_pkg::fmt_1l_16: {next_two_lanes, next_bits} = {1'b0, 5'h10};
            default:
            begin
                {next_two_lanes, next_bits} = {1'b1, 5'h10};
                next_fmt_valid = 1'b0;
            end
        endcase
    end

    // bit 6 of the high register is not used
    assign pattern = {test_pattern_high[`PATTERN_UPPER_MSB:0],
                      test_pattern_low[`PATTERN_LOWER_MSB:`PATTERN_LOWER_LSB]};

    // ==========================================
    // registered outputs
    logic pat_on;
    logic wide_fmt;
    logic [11:0] next_out_a;
    logic [11:0] next_out_b;
    logic [1:0] next_out_extra;
    logic next_outputs_enabled;
    assign pat_on = test_pattern_high[`PATTERN_ENABLE_BIT];
    // extra slots exist only in 14 and 16 bit serialization
    assign wide_fmt = next_bits != 5'h0C;

    // pattern replaces conversion data on both channels
    always_comb
    begin
        next_out_a = conv_a;
        next_out_b = conv_b;
        next_out_extra = 2'h0;
        if (pat_on)
        begin
            next_out_a = pattern;
            next_out_b = pattern;
        end
        // extra bits have no use outside the wide formats
        if (pat_on && wide_fmt)
        begin
            next_out_extra = test_pattern_low[`PATTERN_EXTRA_MSB:0];
        end
        next_outputs_enabled = !output_mode_control[`OUTPUT_DISABLE_BIT];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_a <= 12'h000;
            out_b <= 12'h000;
            out_extra <= 2'h0;
            outputs_enabled <= 1'b1;
            pattern_active <= 1'b0;
            driver_current_tenth_ma <= `CURRENT_DEFAULT;
            termination_enable <= 1'b0;
            two_lanes <= 1'b1;
            serial_bits <= 5'h10;
            format_valid <= 1'b1;
        end
        else
        begin
            out_a <= next_out_a;
            out_b <= next_out_b;
            out_extra <= next_out_extra;
            outputs_enabled <= next_outputs_enabled;
            pattern_active <= pat_on;
            driver_current_tenth_ma <= next_current;
            termination_enable <= output_mode_control[`TERMINATION_BIT];
            two_lanes <= next_two_lanes;
            serial_bits <= next_bits;
            format_valid <= next_fmt_valid;
        end
    end
endmodule

// file: tb/adc_out_regs_checker.sv
// port-level assertions for the output mode register bank
`timescale 1ns/1ps
module adc_out_regs_checker
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // serial
    input wire logic cs_n,
    input wire logic sdo_oe,
    // data path
    input wire logic [11:0] conv_a,
    input wire logic [11:0] conv_b,
    input wire logic [11:0] out_a,
    input wire logic [11:0] out_b,
    input wire logic [1:0] out_extra,
    input wire logic outputs_enabled,
    input wire logic pattern_active,
    // controls
    input wire logic [5:0] driver_current_tenth_ma,
    input wire logic termination_enable,
    input wire logic two_lanes,
    input wire logic [4:0] serial_bits,
    input wire logic format_valid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // ==========================================
    // assertions
    data_pass_a: assert property ($past(arst_n) && $past(arst_n, 2) && !pattern_active
        && !$past(pattern_active) |-> out_a == $past(conv_a) && out_b == $past(conv_b))
        else $error("conversion data not passed through");
    pattern_same_a: assert property (pattern_active && $past(pattern_active)
        |-> out_a == out_b) else $error("channels differ under test pattern");
    extra_use_a: assert property (out_extra != 2'h0
        |-> pattern_active && serial_bits != 5'h0C) else $error("extra bits misused");
    current_code_a: assert property (driver_current_tenth_ma inside
        {6'h28, 6'h2D, 6'h1E, 6'h19, 6'h15, 6'h23}) else $error("bad driver current");
    fmt_unused_a: assert property (!format_valid
        |-> two_lanes && serial_bits == 5'h10) else $error("unused format decode");
    fmt_twelve_a: assert property (serial_bits == 5'h0C |-> format_valid)
        else $error("twelve bit format flagged invalid");
    sdo_idle_a: assert property (cs_n [*8] |-> !sdo_oe)
        else $error("sdo driven outside frame");
    cfg_stable_a: assert property (cs_n [*8] |-> $stable(termination_enable)
        && $stable(driver_current_tenth_ma) && $stable(pattern_active))
        else $error("configuration changed without a frame");

    pattern_on_c: cover property (pattern_active);
    outputs_off_c: cover property (!outputs_enabled);
    extra_on_c: cover property (out_extra == 2'h3);
endmodule

// file: tb/adc_out_host.sv
// serial host model: 16-bit words, link clock idle low between frames
`timescale 1ns/1ps
module adc_out_host
(
    // clock
    input wire logic core_clk,
    // serial pins
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // short frames (nbits < 16) abort the word
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge core_clk);
        cs_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            sdi <= word[15 - i];
            repeat (4) @(posedge core_clk);
            sck <= 1'b1;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            if (i >= 8)
                rd[15 - i] = sdo;
            @(posedge core_clk);
            sck <= 1'b0;
        end
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

// file: tb/adc_out_regs_tb_top.sv
// testbench top for the output mode register bank
`timescale 1ns/1ps
module adc_out_regs_tb_top;
    logic core_clk, arst_n = 1'b0, cs_n, sck, sdi, sdo_out, sdo_oe;
    logic [11:0] conv_a = 12'h000, conv_b = 12'h0F0, out_a, out_b;
    logic [1:0] out_extra;
    logic outputs_enabled, pattern_active, termination_enable, two_lanes, format_valid;
    logic [5:0] driver_current_tenth_ma;
    logic [4:0] serial_bits;
    int error_cnt = 0, checks = 0, cyc = 0;
    wire sdo = sdo_oe ? 1'b0 : 1'b1;

    adc_out_regs adc_out_regs_i (.core_clk, .arst_n, .cs_n, .sck, .sdi, .sdo_out, .sdo_oe,
        .conv_a, .conv_b, .out_a, .out_b, .out_extra, .outputs_enabled, .pattern_active,
        .driver_current_tenth_ma, .termination_enable, .two_lanes, .serial_bits,
        .format_valid);
    adc_out_host adc_out_host_i (.core_clk, .cs_n, .sck, .sdi, .sdo);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        conv_a <= conv_a + 12'h001;
        conv_b <= conv_b - 12'h003;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ==========================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        adc_out_host_i.xfer({1'b0, a, d}, 16, q);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        adc_out_host_i.xfer({1'b1, a, 8'hA5}, 16, q);
        chk(16'(q), 16'(exp));
    endtask

    task automatic close_out();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_mode();
        logic [7:0] d;
        logic [5:0] cur;
        logic [4:0] bits;
        for (int i = 0; i < 8; i++)
        begin
            d = {i[2:0], i[0], i[1], i[2:0]};
            wr(7'h02, d);
            case (i)
                1: cur = 6'h28;
                2: cur = 6'h2D;
                4: cur = 6'h1E;
                5: cur = 6'h19;
                6: cur = 6'h15;
                default: cur = 6'h23;
            endcase
            case (i)
                1, 5: bits = 5'h0E;
                2, 6: bits = 5'h0C;
                default: bits = 5'h10;
            endcase
            chk(16'(driver_current_tenth_ma), 16'(cur));
            chk(16'(termination_enable), 16'(d[4]));
            chk(16'(outputs_enabled), 16'(!d[3]));
            chk(16'({two_lanes, serial_bits, format_valid}),
                16'({i < 5, bits, i != 3 && i != 4}));
            rd(7'h02, d);
        end
    endtask

    task automatic t_pattern();
        wr(7'h02, 8'h01);
        wr(7'h04, 8'h9F);
        wr(7'h03, 8'hEA);
        chk(16'(pattern_active), 16'h0001);
        chk(16'(out_a), 16'h0AA7);
        chk(16'(out_b), 16'h0AA7);
        chk(16'(out_extra), 16'h0003);
        rd(7'h04, 8'h9F);
        wr(7'h02, 8'h02);
        chk(16'(out_extra), 16'h0000);
        wr(7'h03, 8'h2A);
        @(negedge core_clk);
        chk(16'(out_a), 16'(conv_a - 12'h001));
        chk(16'(out_b), 16'(conv_b + 12'h003));
    endtask

    task automatic t_refuse();
        logic [7:0] q;
        wr(7'h02, 8'h55);
        adc_out_host_i.xfer({1'b1, 7'h02, 8'hFF}, 16, q);
        chk(16'(q), 16'h0055);
        adc_out_host_i.xfer({1'b0, 7'h02, 8'h00}, 8, q);
        wr(7'h05, 8'h77);
        rd(7'h05, 8'h00);
        rd(7'h02, 8'h55);
    endtask

    task automatic t_soft_reset();
        wr(7'h03, 8'hBF);
        wr(7'h04, 8'hFF);
        chk(16'(pattern_active), 16'h0001);
        chk(16'(out_a), 16'h0FFF);
        wr(7'h00, 8'h80);
        chk(16'(pattern_active), 16'h0000);
        rd(7'h02, 8'h00);
        rd(7'h03, 8'h00);
        rd(7'h04, 8'h00);
        rd(7'h00, 8'h00);
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(16'(driver_current_tenth_ma), 16'h0023);
        chk(16'(sdo_out), 16'h0000);
        t_mode();
        t_pattern();
        t_refuse();
        t_soft_reset();
        close_out();
    end
endmodule

bind adc_out_regs adc_out_regs_checker adc_out_regs_checker_i (.core_clk, .arst_n, .cs_n,
    .sdo_oe, .conv_a, .conv_b, .out_a, .out_b, .out_extra, .outputs_enabled,
    .pattern_active, .driver_current_tenth_ma, .termination_enable, .two_lanes,
    .serial_bits, .format_valid);
